// >>> rtl/dtt_consts.svh
// Offsets, limits and timing counts for the dual and teaching timer
`ifndef DTT_CONSTS_SVH
`define DTT_CONSTS_SVH

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define DTT_CLK_PERIOD_NS 100
`define DTT_BASE_TICK_NS 1000000
`define DTT_MS_CYCLES (`DTT_BASE_TICK_NS / `DTT_CLK_PERIOD_NS)
`define DTT_DECADE_LAST 4'h9
`define DTT_COUNT_MAX 16'hFFFF

// ---------------------------------------------
// Address limits
// ---------------------------------------------
`define DTT_RELAY_LAST 16'd2557
`define DTT_BANK0_LAST 16'd1999
`define DTT_BANK1_FIRST 16'd2000
`define DTT_BANK1_LAST 16'd7999
`define DTT_BANK2_FIRST 16'd10000
`define DTT_BANK2_LAST 16'd49999
`define DTT_DUAL_WORDS 16'd2
`define DTT_LEARN_WORDS 16'd3

`endif

// >>> rtl/dtt_pkg.sv
// Types shared by the dual and teaching timer
package dtt_pkg;

    // ---------------------------------------------
    // Time base selection
    // ---------------------------------------------
    typedef enum logic [1:0] {
        DTT_BASE_1S = 2'b00,
        DTT_BASE_100MS = 2'b01,
        DTT_BASE_10MS = 2'b10,
        DTT_BASE_1MS = 2'b11
    } dtt_base_t;

    // ---------------------------------------------
    // Dual timer phase
    // ---------------------------------------------
    typedef enum logic [1:0] {
        DTT_IDLE = 2'b00,
        DTT_ON = 2'b01,
        DTT_OFF = 2'b10
    } dtt_phase_t;

    // ---------------------------------------------
    // Operand bundles
    // ---------------------------------------------
    typedef struct packed {
        dtt_base_t base;
        logic [15:0] on_duration_operand;
        logic [15:0] off_duration_operand;
        logic [15:0] pulse_or_result_target;
        logic [15:0] work_area_base;
    } dtt_dual_cfg_t;

    typedef struct packed {
        logic [15:0] word0;
        logic [15:0] word1;
    } dtt_dual_work_t;

    typedef struct packed {
        logic [15:0] result;
        logic [15:0] work1;
        logic [15:0] work2;
    } dtt_learn_words_t;

endpackage

// >>> rtl/dtt_timer.sv
// Dual pulse timer and high time learner for the scan engine
//
// Contract
// - While enabled, output runs on duration high then off duration low.
// - Four bases per instance: 1 s, 100 ms, 10 ms, 1 ms per count.
// - With 1 ms base the full 16-bit count reaches 65.535 s.
// - Dual timer state lives in two consecutive work words.
// - Dual work base only in 0-1998, 2000-7998 or 10000-49998.
// - Output target only relay 0 through 2557; others rejected.
// - Dual timer from interrupt context sets error flag and indicator.
// - While start high, measure high time in 100 ms units, write running.
// - Measured value covers 0 through 6553.5 s, full 16-bit count.
// - On start rise, clear result word to zero before accumulating.
// - On start fall, stop and hold last measured value.
// - Learner occupies three words: result then two work words.
// - Learner base only in 0-1997, 2000-7997 or 10000-49997.
// - Learner from interrupt context sets error flag and indicator.
`timescale 1ns/1ns
`include "dtt_consts.svh"

module dtt_timer
    import dtt_pkg::*;
#(
    parameter int MS_CYCLES = `DTT_MS_CYCLES
) (
    // Clock, reset, freeze
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Execution context
    input wire logic in_interrupt,
    input wire logic err_clear,
    // Dual pulse timer
    input wire logic dual_enable,
    input wire dtt_dual_cfg_t dual_cfg,
    output logic pulse_out,
    output logic dual_reject,
    output dtt_dual_work_t dual_work,
    // High time learner
    input wire logic learn_start,
    input wire logic [15:0] learn_base,
    output logic learn_reject,
    output dtt_learn_words_t learn_words,
    // Error reporting
    output logic exec_error_flag,
    output logic err_led
);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------

    // Whole span of words must land inside one bank
    function automatic logic span_ok(input logic [15:0] base,
                                     input logic [15:0] words);
        logic [16:0] last;
        last = {1'b0, base} + {1'b0, words} - 17'd1;
        span_ok = (last <= {1'b0, `DTT_BANK0_LAST}) ||
                  (base >= `DTT_BANK1_FIRST &&
                   last <= {1'b0, `DTT_BANK1_LAST}) ||
                  (base >= `DTT_BANK2_FIRST &&
                   last <= {1'b0, `DTT_BANK2_LAST});
    endfunction

    // Decade stage: wraps at nine; carry is decoded by the tick wires
    function automatic logic [3:0] decade_next(input logic [3:0] cnt,
                                               input logic step);
        if (!step) begin
            decade_next = cnt;
        end else if (cnt == `DTT_DECADE_LAST) begin
            decade_next = 4'h0;
        end else begin
            decade_next = cnt + 4'h1;
        end
    endfunction

    // ---------------------------------------------
    // Time base ladder
    // ---------------------------------------------
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    logic [15:0] ms_cnt;
    logic [3:0] dec10;
    logic [3:0] dec100;
    logic [3:0] dec1s;
    wire tick_1ms = (ms_cnt == MS_LAST);
    wire tick_10ms = tick_1ms && (dec10 == `DTT_DECADE_LAST);
    wire tick_100ms = tick_10ms && (dec100 == `DTT_DECADE_LAST);
    wire tick_1s = tick_100ms && (dec1s == `DTT_DECADE_LAST);

    // One shared ladder keeps all bases phase aligned
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt <= 16'h0000;
            dec10 <= 4'h0;
            dec100 <= 4'h0;
            dec1s <= 4'h0;
        end else if (clk_en) begin
            ms_cnt <= tick_1ms ? 16'h0000 : ms_cnt + 16'h0001;
            dec10 <= decade_next(dec10, tick_1ms);
            dec100 <= decade_next(dec100, tick_10ms);
            dec1s <= decade_next(dec1s, tick_100ms);
        end
    end

    // ---------------------------------------------
    // Dual pulse timer decode
    // ---------------------------------------------
    dtt_phase_t phase;
    dtt_phase_t next_phase;
    logic [15:0] elapsed;
    logic [15:0] next_elapsed;
    logic base_tick;

    always_comb begin
        unique case (dual_cfg.base)
            DTT_BASE_1S: base_tick = tick_1s;
            DTT_BASE_100MS: base_tick = tick_100ms;
            DTT_BASE_10MS: base_tick = tick_10ms;
            DTT_BASE_1MS: base_tick = tick_1ms;
        endcase
    end

    wire target_ok = (dual_cfg.pulse_or_result_target <= `DTT_RELAY_LAST);
    wire dual_base_ok = span_ok(dual_cfg.work_area_base, `DTT_DUAL_WORDS);
    wire dual_cfg_ok = target_ok && dual_base_ok;
    // Interrupt context never runs the timer, it only flags
    wire dual_run = dual_enable && dual_cfg_ok && !in_interrupt;
    wire [15:0] cur_dur = (phase == DTT_ON) ?
                          dual_cfg.on_duration_operand :
                          dual_cfg.off_duration_operand;
    // phase ends once elapsed count equals the current duration operand
    wire phase_done = (elapsed == cur_dur);

    always_comb begin
        next_phase = phase;
        next_elapsed = elapsed;
        if (!dual_run) begin
            next_phase = DTT_IDLE;
            next_elapsed = 16'h0000;
        end else begin
            unique case (phase)
                DTT_IDLE: begin
                    next_phase = DTT_ON;
                    next_elapsed = 16'h0000;
                end
                DTT_ON, DTT_OFF: begin
                    if (phase_done) begin
                        next_phase = (phase == DTT_ON) ? DTT_OFF : DTT_ON;
                        next_elapsed = 16'h0000;
                    end else if (base_tick) begin
                        next_elapsed = elapsed + 16'h0001;
                    end
                end
                default: begin
                    next_phase = DTT_IDLE;
                    next_elapsed = 16'h0000;
                end
            endcase
        end
    end

    // Phase, elapsed count and registered output
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= DTT_IDLE;
            elapsed <= 16'h0000;
            pulse_out <= 1'b0;
        end else if (clk_en) begin
            phase <= next_phase;
            elapsed <= next_elapsed;
            pulse_out <= (next_phase == DTT_ON);
        end
    end

    assign dual_work.word0 = elapsed;
    assign dual_work.word1 = {14'h0000, phase};
    assign dual_reject = dual_enable && !dual_cfg_ok;

    // ---------------------------------------------
    // High time learner
    // ---------------------------------------------
    logic learn_prev;
    logic [15:0] result;
    logic [15:0] next_result;
    wire learn_base_ok = span_ok(learn_base, `DTT_LEARN_WORDS);
    wire learn_run = learn_start && learn_base_ok && !in_interrupt;
    wire learn_rise = learn_run && !learn_prev;

    // Result update; saturation stops a wrap back to zero
    // full count saturates
    always_comb begin
        next_result = result;
        if (learn_rise) begin
            next_result = 16'h0000;
        end else if (learn_run && tick_100ms &&
                     result != `DTT_COUNT_MAX) begin
            next_result = result + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            learn_prev <= 1'b0;
            result <= 16'h0000;
        end else if (clk_en) begin
            learn_prev <= learn_run;
            result <= next_result;
        end
    end

    assign learn_words.result = result;
    assign learn_words.work1 = {15'h0000, learn_prev};
    assign learn_words.work2 = {12'h000, dec1s};
    assign learn_reject = learn_start && !learn_base_ok;

    // ---------------------------------------------
    // Execution error
    // ---------------------------------------------
    // dual timer or learner in interrupt
    wire err_set = in_interrupt && (dual_enable || learn_start);

    // Set beats clear so a same-cycle misuse is not lost
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            exec_error_flag <= 1'b0;
        end else if (clk_en) begin
            exec_error_flag <= err_set || (exec_error_flag && !err_clear);
        end
    end

    assign err_led = exec_error_flag;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_enable_low_clears: assert property (
        clk_en && !dual_run |=> phase == DTT_IDLE && elapsed == 16'h0000
    ) else $error("dual timer not cleared after enable low");

    a_start_in_on: assert property (
        clk_en && dual_run && phase == DTT_IDLE |=> pulse_out
    ) else $error("dual timer did not start in on phase");

    a_phase_flip: assert property (
        clk_en && dual_run && phase == DTT_ON && phase_done
        |=> phase == DTT_OFF && !pulse_out
    ) else $error("on phase did not end at its duration");

    a_phase_hold: assert property (
        clk_en && dual_run && phase == DTT_OFF && !phase_done
        |=> phase == DTT_OFF
    ) else $error("off phase ended early");

    a_target_reject: assert property (
        clk_en && dual_cfg.pulse_or_result_target > `DTT_RELAY_LAST
        |=> !pulse_out
    ) else $error("pulse driven to a rejected target");

    a_error_set: assert property (
        clk_en && in_interrupt && dual_enable |=> exec_error_flag && err_led
    ) else $error("interrupt use of dual timer not flagged");

    a_learn_error: assert property (
        clk_en && in_interrupt && learn_start |=> exec_error_flag
    ) else $error("interrupt use of learner not flagged");

    a_rise_clears: assert property (
        clk_en && learn_rise |=> result == 16'h0000
    ) else $error("result not cleared on start rise");

    a_learn_step: assert property (
        clk_en && learn_run && learn_prev && tick_100ms &&
        result != `DTT_COUNT_MAX |=> result == $past(result) + 16'h0001
    ) else $error("result did not advance on 100 ms tick");

    a_learn_saturate: assert property (
        clk_en && learn_run && learn_prev && result == `DTT_COUNT_MAX
        |=> result == `DTT_COUNT_MAX
    ) else $error("result wrapped past full count");

    a_learn_hold: assert property (
        !learn_run && !$past(learn_run) |-> $stable(result)
    ) else $error("result changed while start low");

    a_tick_width: assert property (
        clk_en && tick_1ms && MS_CYCLES > 1 |=> !tick_1ms
    ) else $error("base tick longer than one cycle");

    c_pulse_cycle: cover property (
        $rose(pulse_out) ##[1:1000] $fell(pulse_out)
    );
    c_learn_done: cover property (
        $fell(learn_prev) && result != 16'h0000
    );
    c_error_raise: cover property ($rose(exec_error_flag));

endmodule

// >>> verification/dtt_timer_tb.sv
// Self-checking bench for the dual pulse timer and high time learner
`timescale 1ns/1ns

module testbench
    import dtt_pkg::*;
;
    // ------------------------------------------
    // Signals and counters
    // ------------------------------------------
    localparam int MSC = 4;
    logic ref_clk, rstn, clk_en, in_interrupt, err_clear;
    logic dual_enable, pulse_out, dual_reject;
    dtt_dual_cfg_t dual_cfg;
    dtt_dual_work_t dual_work;
    logic learn_start, learn_reject;
    logic [15:0] learn_base;
    dtt_learn_words_t learn_words;
    logic exec_error_flag, err_led;
    int n_mismatch = 0;
    int comparisons = 0;
    // Tick period in cycles for each base code
    int per[4] = '{4000, 400, 40, 4};

    // Short count so every base fits the run
    // work words observed only
    dtt_timer #(.MS_CYCLES(MSC)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .in_interrupt(in_interrupt), .err_clear(err_clear),
        .dual_enable(dual_enable), .dual_cfg(dual_cfg),
        .pulse_out(pulse_out), .dual_reject(dual_reject),
        .dual_work(dual_work), .learn_start(learn_start),
        .learn_base(learn_base), .learn_reject(learn_reject),
        .learn_words(learn_words), .exec_error_flag(exec_error_flag),
        .err_led(err_led)
    );

    // ------------------------------------------
    // Compare helpers
    // ------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Range check; tick phase is free so spans have slack
    task automatic rng(input logic [31:0] got, input int lo, input int hi);
        comparisons++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic int lo_of(input int d, input int p);
        return (d == 0) ? 1 : (d - 1) * p + 1;
    endfunction

    task automatic summarize();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    // One on and one off span on a base, then disable
    task automatic t_dual(input int b, input int on, input int off);
        int n;
        int p;
        p = per[b];
        @(posedge ref_clk);
        dual_cfg <= {dtt_base_t'(b), on[15:0], off[15:0], 16'd10, 16'd100};
        dual_enable <= 1'b1;
        n = 0;
        do begin @(negedge ref_clk); n++; end
        while (pulse_out !== 1'b1 && n < 3);
        rng(n, 1, 2);
        n = 0;
        while (pulse_out === 1'b1 && n < on * p + 9) begin
            @(negedge ref_clk);
            n++;
        end
        rng(n, lo_of(on, p), on * p + 1);
        chk(dual_work.word1, {14'h0, DTT_OFF});
        n = 0;
        while (pulse_out === 1'b0 && n < off * p + 9) begin
            @(negedge ref_clk);
            n++;
        end
        rng(n, lo_of(off, p), off * p + 1);
        @(posedge ref_clk);
        dual_enable <= 1'b0;
        // Enable low is only taken at the following edge
        repeat (2) @(negedge ref_clk);
        chk(pulse_out, 1'b0);
        chk(dual_work, 32'h0);
    endtask

    // Target and work base edges, both timers
    task automatic t_reject();
        logic [15:0] tg[11] = '{2557, 2558, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        logic [15:0] wb[11] = '{0, 0, 1998, 1999, 2000, 7998, 7999,
                                9999, 10000, 49998, 49999};
        logic ex[11] = '{0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1};
        logic [15:0] lb[8] = '{1997, 1998, 2000, 7997, 7998, 9999,
                               49997, 49998};
        logic lx[8] = '{0, 1, 0, 0, 1, 1, 0, 1};
        for (int i = 0; i < 11; i++) begin
            @(posedge ref_clk);
            dual_cfg <= {DTT_BASE_1MS, 16'd1, 16'd1, tg[i], wb[i]};
            dual_enable <= 1'b1;
            repeat (3) @(negedge ref_clk);
            chk(dual_reject, ex[i]);
            chk(pulse_out, !ex[i]);
            @(posedge ref_clk);
            dual_enable <= 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            learn_base <= lb[i];
            learn_start <= 1'b1;
            @(negedge ref_clk);
            chk(learn_reject, lx[i]);
        end
        @(posedge ref_clk);
        learn_start <= 1'b0;
    endtask

    // Interrupt context on one function, then clear
    task automatic t_err(input logic learner);
        logic [15:0] keep;
        keep = learn_words.result;
        @(posedge ref_clk);
        in_interrupt <= 1'b1;
        dual_cfg <= {DTT_BASE_1MS, 16'd1, 16'd1, 16'd10, 16'd100};
        learn_base <= 16'd100;
        if (learner) learn_start <= 1'b1;
        else dual_enable <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(exec_error_flag, 1'b1);
        chk(err_led, 1'b1);
        chk(pulse_out, 1'b0);
        chk(learn_words.result, keep);
        // Clear during ongoing misuse loses to the set
        @(posedge ref_clk);
        err_clear <= 1'b1;
        @(posedge ref_clk);
        err_clear <= 1'b0;
        @(negedge ref_clk);
        chk(exec_error_flag, 1'b1);
        @(posedge ref_clk);
        {in_interrupt, learn_start, dual_enable} <= 3'h0;
        err_clear <= 1'b1;
        @(posedge ref_clk);
        err_clear <= 1'b0;
        @(negedge ref_clk);
        chk(exec_error_flag, 1'b0);
    endtask

    // Two measured runs, hold, restart and freeze
    task automatic t_learn();
        logic [15:0] keep;
        int n;
        @(posedge ref_clk);
        learn_base <= 16'd100;
        learn_start <= 1'b1;
        repeat (1000) @(posedge ref_clk);
        @(negedge ref_clk);
        rng(learn_words.result, 2, 3);
        chk(learn_words.work1, 32'h1);
        rng(learn_words.work2, 0, 9);
        @(posedge ref_clk);
        learn_start <= 1'b0;
        repeat (3) @(negedge ref_clk);
        keep = learn_words.result;
        repeat (500) @(negedge ref_clk);
        chk(learn_words.result, keep);
        @(posedge ref_clk);
        learn_start <= 1'b1;
        n = 0;
        do begin @(negedge ref_clk); n++; end
        while (learn_words.result !== 16'h0 && n < 3);
        rng(n, 1, 2);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        // A tick may still land on the freeze edge itself
        @(negedge ref_clk);
        keep = learn_words.result;
        repeat (900) @(negedge ref_clk);
        chk(learn_words.result, keep);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (600) @(negedge ref_clk);
        rng(learn_words.result, 1, 2);
        @(posedge ref_clk);
        learn_start <= 1'b0;
    endtask

    // ------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // About four times the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        summarize();
    end

    initial begin
        {rstn, in_interrupt, err_clear, dual_enable, learn_start} = 5'h0;
        clk_en = 1'b1;
        dual_cfg = '0;
        learn_base = 16'h0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({pulse_out, exec_error_flag, err_led}, 3'h0);
        chk(dual_work, 32'h0);
        chk(learn_words.result, 16'h0);
        @(posedge ref_clk);
        rstn <= 1'b1;
        t_dual(0, 1, 0);
        t_dual(1, 2, 1);
        t_dual(2, 3, 2);
        t_dual(3, 250, 125);
        t_reject();
        t_err(1'b0);
        t_err(1'b1);
        t_learn();
        summarize();
    end
endmodule
